// file: hdl/modulo_timer_counter_core.sv
// Modulo timer counter core: 16-bit up counter, prescaler, modulo wrap, overflow flag and request,
// byte-latched counter reads, stop, debug-break and channel mode configuration.
// Assumes on-chip stop, break and break-clear-enable levels on clk; the external clock pin is async.
`timescale 1ns/10ps
module modulo_timer_counter_core
    import timer_pkg::*;
(
    input wire logic clk,                       // Bus clock, 125 MHz
    input wire logic reset,                     // Synchronous, active high
    input wire logic [ADDR_W-1:0] addr,         // Register address
    input wire logic [DATA_W-1:0] wdata,        // Write data
    input wire logic wr,                        // Write strobe
    input wire logic rd,                        // Read strobe
    output logic [DATA_W-1:0] rdata,            // Read data, cycle after rd
    input wire logic external_timer_clock,      // External clock pin, asynchronous
    input wire logic stop_mode,                 // System in stop mode
    input wire logic break_active,              // Debug break state
    input wire logic break_clear_enable,        // Flags may be cleared in break
    output logic overflow_irq,                  // Overflow interrupt request level
    output logic capture_enable,                // Input capture allowed
    output logic [CH_COUNT-1:0] channel_compare, // Per channel: 1 compare, 0 capture
    output logic [1:0] channel_buffered         // Buffered mode of channels 0 and 2
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] modulo;
        logic ovf_flag;
        logic ovf_ie;
        logic halt;
        logic [PS_W-1:0] ps;
        logic clear_armed;
        logic [7:0] low_latch;
        logic low_latched;
        logic mod_pending;
        logic [CH_COUNT-1:0] ch_compare;
        logic [1:0] ch_buf;
        logic [DATA_W-1:0] rdata;
        logic irq;
        logic cap_en;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;
    logic run;
    logic tick;
    logic clear_wr;
    logic status_wr;
    logic flag_clear_ok;
    logic [15:0] count_step;
    logic ovf_event;

    assign status_wr = wr && addr == REG_STATUS_CONTROL;
    assign clear_wr = status_wr && wdata[CLEAR_BIT];
    // Stop, break and halt all freeze both counter and prescaler
    assign run = !s_r.halt && !stop_mode && !break_active;
    // With break clear disabled, register traffic in break leaves flags alone
    assign flag_clear_ok = !break_active || break_clear_enable;

    // ----------------------------------------
    // Prescaler and external clock
    // ----------------------------------------
    tick_prescaler #(
        .DIV_W(PRESCALE_W)
    ) u_prescaler (
        .clk(clk),
        .reset(reset),
        .ext_pin(external_timer_clock),
        .run(run),
        .restart(clear_wr),
        .ps_sel(s_r.ps),
        .tick(tick)
    );

    // ----------------------------------------
    // Counter and overflow
    // ----------------------------------------
    always_comb begin
        if (s_r.count == s_r.modulo) begin
            count_step = COUNT_RESET;
        end else begin
            count_step = s_r.count + 16'h0001;
        end
        // High byte written alone holds the flag off until the pair is complete
        ovf_event = tick && !clear_wr && count_step == s_r.modulo && !s_r.mod_pending;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = BYTE_ZERO;

        if (tick) begin
            s_nxt.count = count_step;
        end

        // Register reads
        if (rd) begin
            case (addr)
                REG_STATUS_CONTROL: begin
                    s_nxt.rdata = {s_r.ovf_flag, s_r.ovf_ie, s_r.halt, 2'b00, s_r.ps};
                    if (s_r.ovf_flag && flag_clear_ok) begin
                        s_nxt.clear_armed = 1'b1;
                    end
                end
                REG_COUNT_HIGH: begin
                    s_nxt.rdata = s_r.count[15:8];
                    if (!s_r.low_latched) begin
                        s_nxt.low_latch = s_r.count[7:0];
                        s_nxt.low_latched = 1'b1;
                    end
                end
                REG_COUNT_LOW: begin
                    s_nxt.rdata = s_r.low_latched ? s_r.low_latch : s_r.count[7:0];
                    s_nxt.low_latched = 1'b0;
                end
                REG_MODULO_HIGH: begin
                    s_nxt.rdata = s_r.modulo[15:8];
                end
                REG_MODULO_LOW: begin
                    s_nxt.rdata = s_r.modulo[7:0];
                end
                REG_CHANNEL_CONFIG: begin
                    s_nxt.rdata = {2'b00, s_r.ch_buf, s_r.ch_compare};
                end
                default: begin
                    s_nxt.rdata = BYTE_ZERO;
                end
            endcase
        end

        // Register writes, visible on the next edge; only a status write with the clear bit restarts the divider
        if (wr) begin
            case (addr)
                REG_STATUS_CONTROL: begin
                    s_nxt.ovf_ie = wdata[OVF_IE_BIT];
                    s_nxt.halt = wdata[HALT_BIT];
                    s_nxt.ps = wdata[PS_LSB +: PS_W];
                    if (flag_clear_ok) begin
                        // An armed clear made before a break still completes here
                        if (s_r.clear_armed && !wdata[OVF_FLAG_BIT]) begin
                            s_nxt.ovf_flag = 1'b0;
                        end
                        s_nxt.clear_armed = 1'b0;
                    end
                    if (wdata[CLEAR_BIT]) begin
                        s_nxt.count = COUNT_RESET;
                        s_nxt.low_latch = BYTE_ZERO;
                    end
                end
                REG_MODULO_HIGH: begin
                    s_nxt.modulo[15:8] = wdata;
                    s_nxt.mod_pending = 1'b1;
                end
                REG_MODULO_LOW: begin
                    s_nxt.modulo[7:0] = wdata;
                    s_nxt.mod_pending = 1'b0;
                end
                REG_CHANNEL_CONFIG: begin
                    s_nxt.ch_compare = wdata[CH_MODE_LSB +: CH_COUNT];
                    s_nxt.ch_buf = {wdata[CH_BUF2_BIT], wdata[CH_BUF0_BIT]};
                end
                default: begin
                    s_nxt.ch_buf = s_r.ch_buf;
                end
            endcase
        end

        // A new overflow beats any clear in the same cycle and disarms the sequence
        if (ovf_event) begin
            s_nxt.ovf_flag = 1'b1;
            s_nxt.clear_armed = 1'b0;
        end

        // Request is not gated by wait mode so it can wake the system
        s_nxt.irq = s_nxt.ovf_flag && s_nxt.ovf_ie;
        s_nxt.cap_en = !s_nxt.halt;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '{count: COUNT_RESET, modulo: MODULO_RESET, ovf_flag: 1'b0, ovf_ie: 1'b0,
                     halt: 1'b1, ps: 3'h0, clear_armed: 1'b0, low_latch: BYTE_ZERO, low_latched: 1'b0,
                     mod_pending: 1'b0, ch_compare: 4'h0, ch_buf: 2'h0, rdata: BYTE_ZERO,
                     irq: 1'b0, cap_en: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign rdata = s_r.rdata;
    assign overflow_irq = s_r.irq;
    assign capture_enable = s_r.cap_en;
    assign channel_compare = s_r.ch_compare;
    assign channel_buffered = s_r.ch_buf;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    stop_freeze_a: assert property (stop_mode && !clear_wr |=> $stable(s_r.count))
        else $error("counter moved in stop mode");
    break_freeze_a: assert property (break_active && !clear_wr |=> s_r.count == $past(s_r.count))
        else $error("counter moved during break");
    break_protect_a: assert property (break_active && !break_clear_enable && s_r.ovf_flag |=> s_r.ovf_flag)
        else $error("flag cleared during protected break");
    halt_freeze_a: assert property ((s_r.halt && !clear_wr) [*2] |=> $stable(s_r.count))
        else $error("halted counter advanced");
    overflow_set_a: assert property (ovf_event |=> s_r.ovf_flag ##1 s_r.ovf_flag || $past(status_wr))
        else $error("overflow flag not set on reaching modulo");
    wrap_zero_a: assert property (tick && !clear_wr && !wr && s_r.count == s_r.modulo |=> s_r.count == 16'h0000)
        else $error("counter did not restart from zero");
    clear_needs_arm_a: assert property (!s_r.clear_armed && s_r.ovf_flag |=> s_r.ovf_flag)
        else $error("flag cleared without a prior read");
    irq_follow_a: assert property (s_r.ovf_flag && s_r.ovf_ie |=> overflow_irq || !s_r.ovf_flag || !s_r.ovf_ie)
        else $error("overflow request missing");
    irq_mask_a: assert property (!s_r.ovf_ie |-> !overflow_irq)
        else $error("overflow request while disabled");
    capture_halt_a: assert property (s_r.halt |-> !capture_enable)
        else $error("capture enabled while halted");
    clear_zero_a: assert property (clear_wr |=> s_r.count == 16'h0000 && rdata == 8'h00 || $past(rd))
        else $error("clear did not zero the counter");
    halt_clear_a: assert property (clear_wr && wdata[HALT_BIT] ##1 !wr [*2] |-> s_r.count == 16'h0000)
        else $error("halt with clear left counter nonzero");
    latch_hold_a: assert property (s_r.low_latched && !(rd && addr == REG_COUNT_LOW) && !clear_wr
                                   |=> $stable(s_r.low_latch))
        else $error("latched low byte changed");
    mod_inhibit_a: assert property (s_r.mod_pending |=> !$rose(s_r.ovf_flag))
        else $error("overflow set while modulo pair incomplete");

    // ----------------------------------------
    // Register path checks
    // ----------------------------------------
    // Reset release shows the documented idle state on the very next edge
    reset_state_a: assert property ($fell(reset) |-> s_r.halt && s_r.modulo == MODULO_RESET
                                    && s_r.count == COUNT_RESET && !s_r.ovf_flag)
        else $error("state after reset not as documented");
    frozen_tick_a: assert property (s_r.halt || stop_mode || break_active |-> !tick)
        else $error("tick while frozen");
    count_step_a: assert property (tick && !clear_wr && s_r.count != s_r.modulo
                                   |=> s_r.count == $past(s_r.count) + 16'h0001)
        else $error("counter did not step by one");
    rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    status_bits_a: assert property (rd && addr == REG_STATUS_CONTROL
                                    |=> rdata[CLEAR_BIT] == 1'b0 && rdata[3] == 1'b0)
        else $error("clear bit read back nonzero");
    write_one_a: assert property (status_wr && wdata[OVF_FLAG_BIT] && !ovf_event
                                  |=> s_r.ovf_flag == $past(s_r.ovf_flag))
        else $error("writing one changed the flag");
    set_wins_a: assert property (ovf_event |=> s_r.ovf_flag && !s_r.clear_armed)
        else $error("new overflow did not win over the clear");
    break_arm_a: assert property (break_active && !break_clear_enable && !s_r.clear_armed
                                  |=> !s_r.clear_armed)
        else $error("clear armed during protected break");
    arm_survive_a: assert property (break_active && !break_clear_enable && s_r.clear_armed && !ovf_event
                                    |=> s_r.clear_armed)
        else $error("armed clear lost during break");
    irq_set_a: assert property (s_r.ovf_flag && s_r.ovf_ie |-> overflow_irq)
        else $error("overflow request not raised");
    halt_write_a: assert property (status_wr |=> s_r.halt == $past(wdata[HALT_BIT]))
        else $error("halt bit write not taken");
    latch_take_a: assert property (rd && addr == REG_COUNT_HIGH && !s_r.low_latched
                                   |=> s_r.low_latched && s_r.low_latch == $past(s_r.count[7:0]))
        else $error("high byte read did not latch low byte");
    unlatch_a: assert property (rd && addr == REG_COUNT_LOW |=> !s_r.low_latched)
        else $error("low byte read left the latch set");
    mod_pending_a: assert property (wr && addr == REG_MODULO_HIGH |=> s_r.mod_pending)
        else $error("modulo high write did not block overflow");
    channel_out_a: assert property (wr && addr == REG_CHANNEL_CONFIG
                                    |=> channel_compare == $past(wdata[CH_MODE_LSB +: CH_COUNT]))
        else $error("channel mode not taken");

endmodule

// file: hdl/timer_pkg.sv
// Shared constants of the modulo timer counter core: register map, bit positions and reset values.
// Assumes an 8-bit register port with a 3-bit word address.
package timer_pkg;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [2:0] REG_STATUS_CONTROL = 3'h0;
    localparam logic [2:0] REG_COUNT_HIGH = 3'h1;
    localparam logic [2:0] REG_COUNT_LOW = 3'h2;
    localparam logic [2:0] REG_MODULO_HIGH = 3'h3;
    localparam logic [2:0] REG_MODULO_LOW = 3'h4;
    localparam logic [2:0] REG_CHANNEL_CONFIG = 3'h5;

    // ----------------------------------------
    // Status and control fields
    // ----------------------------------------
    localparam int OVF_FLAG_BIT = 7;
    localparam int OVF_IE_BIT = 6;
    localparam int HALT_BIT = 5;
    localparam int CLEAR_BIT = 4;
    localparam int PS_LSB = 0;
    localparam int PS_W = 3;
    localparam logic [2:0] PS_EXTERNAL = 3'h7;

    // ----------------------------------------
    // Channel configuration fields
    // ----------------------------------------
    localparam int CH_COUNT = 4;
    localparam int CH_MODE_LSB = 0;
    localparam int CH_BUF0_BIT = 4;
    localparam int CH_BUF2_BIT = 5;

    // ----------------------------------------
    // Reset values and widths
    // ----------------------------------------
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] MODULO_RESET = 16'hFFFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int PRESCALE_W = 6;

endpackage

// file: hdl/tick_prescaler.sv
// Timer tick source: bus clock divider with selectable tap, or synchronised external clock pin.
// Assumes the external pin is asynchronous to clk and toggles at most at half the clk rate.
`timescale 1ns/10ps
module tick_prescaler
    import timer_pkg::*;
#(
    parameter int DIV_W = PRESCALE_W
) (
    input wire logic clk,            // Bus clock
    input wire logic reset,          // Synchronous, active high
    input wire logic ext_pin,        // External timer clock pin, asynchronous
    input wire logic run,            // Counting allowed
    input wire logic restart,        // Zero the divider
    input wire logic [2:0] ps_sel,   // Prescaler select
    output logic tick                // One-cycle count enable
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic [DIV_W-1:0] div;
    } pre_state_t;

    pre_state_t s_r;
    pre_state_t s_nxt;
    logic [DIV_W:0] tap_onehot;
    logic [DIV_W-1:0] tap_mask;
    logic ext_rise;

    assign tap_onehot = (DIV_W+1)'(1) << ps_sel;
    assign tap_mask = tap_onehot[DIV_W-1:0] - DIV_W'(1);
    // Edge taken from the second and third stages; the first stage feeds only the second
    assign ext_rise = s_r.sync2 && !s_r.sync3;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = ext_pin;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        if (restart) begin
            s_nxt.div = '0;
        end else if (run) begin
            s_nxt.div = s_r.div + DIV_W'(1);
        end
        if (!run || restart) begin
            tick = 1'b0;
        end else if (ps_sel == PS_EXTERNAL) begin
            tick = ext_rise;
        end else begin
            tick = (s_r.div & tap_mask) == tap_mask;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    div_one_a: assert property (run && !restart && ps_sel == 3'h0 |-> tick)
        else $error("divide by one did not tick every cycle");
    div_two_a: assert property (run && !restart && ps_sel == 3'h1 && tick ##1 run && !restart && ps_sel == 3'h1
                                |-> !tick)
        else $error("divide by two ticked twice in a row");
    ext_edge_a: assert property (run && !restart && ps_sel == PS_EXTERNAL && tick
                                 |-> $past(ext_pin, 2) && !$past(ext_pin, 3))
        else $error("external tick without a synchronised rising edge");

endmodule

// file: testbench/ext_clock_source.sv
// Partner model of the external timer clock pin: sends a burst of rising edges on request.
// Assumes the bench raises go for one cycle with pulses set; the pin rests low between bursts.
`timescale 1ns/10ps
module ext_clock_source #(
    parameter int HALF = 16
) (
    input wire logic clk,          // Bus clock
    input wire logic reset,        // Synchronous, active high
    input wire logic go,           // Start a burst
    input wire logic [7:0] pulses, // Edges in the burst
    output logic pin,              // External timer clock pin
    output logic busy              // Burst in progress
);
    int n;
    // Period of 32 bus cycles stays below 4 MHz and half the bus rate; edges land off the clk phase
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go && !reset) begin
                busy <= 1'b1;
                for (n = 0; n < pulses; n++) begin
                    repeat (HALF) @(posedge clk);
                    pin <= #3 1'b1;
                    repeat (HALF) @(posedge clk);
                    pin <= #3 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// file: testbench/modulo_timer_counter_core_tb_top.sv
// Self-checking bench of the modulo timer counter core, one task per scenario.
// Assumes the register map of timer_pkg and the external clock partner model.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
module modulo_timer_counter_core_tb_top;
    import timer_pkg::*;
    logic clk, reset, wr, rd, ext_pin, stop_mode, break_active, break_clear_enable, go, busy;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v, l1, l2;
    logic overflow_irq, capture_enable;
    logic [CH_COUNT-1:0] channel_compare;
    logic [1:0] channel_buffered;
    logic [7:0] pulses;
    int err_total = 0;
    int checked = 0;

    modulo_timer_counter_core u_modulo_timer_counter_core (.clk(clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .external_timer_clock(ext_pin),
        .stop_mode(stop_mode), .break_active(break_active), .break_clear_enable(break_clear_enable),
        .overflow_irq(overflow_irq), .capture_enable(capture_enable),
        .channel_compare(channel_compare), .channel_buffered(channel_buffered));
    ext_clock_source u_ext_clock_source (.clk(clk), .reset(reset), .go(go), .pulses(pulses),
        .pin(ext_pin), .busy(busy));

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
        rd_reg(REG_MODULO_HIGH, v); `CHK(v, 8'hFF)
        rd_reg(REG_MODULO_LOW, v); `CHK(v, 8'hFF)
        rd_reg(REG_COUNT_HIGH, v); `CHK(v, 8'h00)
        rd_reg(REG_COUNT_LOW, v); `CHK(v, 8'h00)
        wr_reg(3'h7, 8'h5A);
        rd_reg(3'h6, v); `CHK(v, 8'h00)
        `CHK(capture_enable, 1'b0)
    endtask
    task automatic t_prescale();
        for (int ps = 0; ps < 7; ps++) begin
            wr_reg(REG_STATUS_CONTROL, 8'h30);
            rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
            rd_reg(REG_COUNT_LOW, v); `CHK(v, 8'h00)
            wr_reg(REG_STATUS_CONTROL, 8'(ps));
            idle(8 << ps);
            wr_reg(REG_STATUS_CONTROL, 8'h20);
            rd_reg(REG_COUNT_LOW, v); `CHK(v >= 8 && v <= 10, 1'b1)
        end
    endtask
    task automatic t_overflow();
        wr_reg(REG_MODULO_HIGH, 8'h00);
        wr_reg(REG_MODULO_LOW, 8'h03);
        wr_reg(REG_STATUS_CONTROL, 8'h50);
        idle(20);
        wr_reg(REG_STATUS_CONTROL, 8'h60);
        `CHK(overflow_irq, 1'b1)
        wr_reg(REG_STATUS_CONTROL, 8'h60);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'hE0)
        wr_reg(REG_STATUS_CONTROL, 8'hE0);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'hE0)
        wr_reg(REG_STATUS_CONTROL, 8'h60);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h60)
        `CHK(overflow_irq, 1'b0)
        wr_reg(REG_STATUS_CONTROL, 8'h10);
        idle(20);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'hA0)
        `CHK(overflow_irq, 1'b0)
    endtask
    task automatic t_break();
        break_active <= 1'b1;
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'hA0)
        break_active <= 1'b0;
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
        wr_reg(REG_STATUS_CONTROL, 8'h10);
        idle(20);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        break_clear_enable <= 1'b1;
        break_active <= 1'b1;
        rd_reg(REG_STATUS_CONTROL, v);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        break_active <= 1'b0;
        break_clear_enable <= 1'b0;
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
    endtask
    task automatic t_freeze();
        wr_reg(REG_MODULO_HIGH, 8'hFF);
        wr_reg(REG_MODULO_LOW, 8'hFF);
        wr_reg(REG_STATUS_CONTROL, 8'h10);
        break_active <= 1'b1;
        rd_reg(REG_COUNT_HIGH, v);
        rd_reg(REG_COUNT_LOW, l1);
        idle(10);
        rd_reg(REG_COUNT_LOW, l2); `CHK(l2, l1)
        break_active <= 1'b0;
        stop_mode <= 1'b1;
        rd_reg(REG_COUNT_LOW, l1);
        idle(10);
        rd_reg(REG_COUNT_LOW, l2); `CHK(l2, l1)
        stop_mode <= 1'b0;
        idle(10);
        rd_reg(REG_COUNT_LOW, l2); `CHK(l2 != l1, 1'b1)
    endtask
    task automatic t_latch();
        wr_reg(REG_STATUS_CONTROL, 8'h16);
        idle(100);
        rd_reg(REG_COUNT_HIGH, v); `CHK(v, 8'h00)
        idle(200);
        rd_reg(REG_COUNT_HIGH, v);
        rd_reg(REG_COUNT_LOW, l1);
        rd_reg(REG_COUNT_LOW, l2);
        v = l2 - l1;
        `CHK(v >= 2 && v <= 4, 1'b1)
    endtask
    task automatic t_mod_inhibit();
        wr_reg(REG_STATUS_CONTROL, 8'h30);
        wr_reg(REG_MODULO_HIGH, 8'h00);
        wr_reg(REG_STATUS_CONTROL, 8'h00);
        idle(300);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
        wr_reg(REG_MODULO_LOW, 8'h10);
        wr_reg(REG_STATUS_CONTROL, 8'h10);
        idle(40);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'hA0)
        wr_reg(REG_STATUS_CONTROL, 8'h90);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h80)
        wr_reg(REG_STATUS_CONTROL, 8'h00);
        wr_reg(REG_STATUS_CONTROL, 8'h20);
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
    endtask
    task automatic t_ext();
        int k;
        wr_reg(REG_MODULO_HIGH, 8'hFF);
        wr_reg(REG_MODULO_LOW, 8'hFF);
        wr_reg(REG_STATUS_CONTROL, 8'h37);
        wr_reg(REG_STATUS_CONTROL, 8'h07);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        idle(2);
        for (k = 0; k < 400 && busy === 1'b1; k++) @(posedge clk);
        idle(10);
        wr_reg(REG_STATUS_CONTROL, 8'h27);
        rd_reg(REG_COUNT_LOW, v); `CHK(v, 8'h05)
    endtask
    task automatic t_channels();
        wr_reg(REG_CHANNEL_CONFIG, 8'h3A);
        idle(1);
        `CHK(channel_compare, 4'hA)
        `CHK(channel_buffered, 2'b11)
        rd_reg(REG_CHANNEL_CONFIG, v); `CHK(v, 8'h3A)
        `CHK(capture_enable, 1'b0)
        wr_reg(REG_STATUS_CONTROL, 8'h00);
        idle(2);
        `CHK(capture_enable, 1'b1)
    endtask
    // Reset taken while in stop mode must bring everything back to its reset value
    task automatic t_stop_reset();
        wr_reg(REG_MODULO_LOW, 8'h55);
        stop_mode <= 1'b1;
        idle(2);
        reset <= 1'b1;
        idle(6);
        reset <= 1'b0;
        stop_mode <= 1'b0;
        rd_reg(REG_MODULO_LOW, v); `CHK(v, 8'hFF)
        rd_reg(REG_STATUS_CONTROL, v); `CHK(v, 8'h20)
        `CHK(channel_compare, 4'h0)
        `CHK(capture_enable, 1'b0)
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        {wr, rd, go, stop_mode, break_active, break_clear_enable} = '0;
        addr = '0;
        wdata = '0;
        pulses = 8'h05;
        idle(6);
        reset <= 1'b0;
        t_reset();
        t_prescale();
        t_overflow();
        t_break();
        t_freeze();
        t_latch();
        t_mod_inhibit();
        t_ext();
        t_channels();
        t_stop_reset();
        close_out();
    end
    // Whole run needs about 2200 cycles; the margin covers slow prescale taps
    initial begin
        idle(50000);
        err_total++;
        close_out();
    end
endmodule
